// file: verilog/radio_host_spi_irq_interface.v
// Radio host serial slave port, bypass bit path and interrupt pin
`timescale 1ns/1ps
`include "radio_spi_defines.vh"
module radio_host_spi_irq_interface #(
   parameter OSC_START_NS  = 2000,
   parameter BYP_HALF_CYC  = 16,
   parameter FIFO_DEPTH    = 16,
   parameter FIFO_AW       = 4
) (
   input  wire       clk_i,
   input  wire       srst_i,
   input  wire       sck_i,
   input  wire       ss_n_i,
   input  wire       mosi_i,
   output reg        miso_o,
   output reg        miso_oe_o,
   input  wire       power_down_pin_n_i,
   output reg        osc_running_o,
   input  wire       irq_i,
   output reg        irq_o,
   output reg        irq_oe_o,
   input  wire       bypass_serial_bit_i,
   output reg        bypass_serial_bit_o,
   output reg        bypass_serial_bit_oe_o,
   input  wire       bypass_bit_valid_i,
   output reg        bypass_bit_valid_o,
   output reg        bypass_bit_valid_oe_o,
   input  wire       tx_mode_i,
   input  wire [1:0] baseband_mode_i,
   input  wire [3:0] tx_event_i,
   input  wire [7:0] rx_event_i,
   input  wire       core_rx_bit_i,
   input  wire       core_rx_valid_i,
   output wire       core_rx_ready_o,
   output wire       core_tx_bit_o,
   output wire       core_tx_valid_o,
   input  wire       core_tx_ready_i
);

   // ****************************************************************
   // Timing constants
   // ****************************************************************
   localparam integer OSC_CYC_I =
      (OSC_START_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US;
   localparam [15:0] OSC_CYC  = (OSC_CYC_I < 1) ? 16'h0001
                                                : OSC_CYC_I[15:0];
   localparam [7:0]  HALF_CYC = (BYP_HALF_CYC < 1) ? 8'h01
                                                   : BYP_HALF_CYC[7:0];

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   wire [`SY_WIDTH-1:0] sy;
   reg                  sck_d1_q;
   wire                 sck_rise;
   wire                 sck_fall;
   wire                 ss_act;

   pin_sync3 #(
      .W (`SY_WIDTH)
   ) u_sync (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .pin_i   ({bypass_bit_valid_i, bypass_serial_bit_i,
                 power_down_pin_n_i, mosi_i, ss_n_i, sck_i}),
      .level_o (sy)
   );

   // SCK edge detection on the filtered level
   always @(posedge clk_i) begin
      if (srst_i) begin
         sck_d1_q <= 1'b0;
      end else begin
         sck_d1_q <= sy[`SY_SCK];
      end
   end

   assign sck_rise = sy[`SY_SCK] & ~sck_d1_q;
   assign sck_fall = ~sy[`SY_SCK] & sck_d1_q;
   assign ss_act   = ~sy[`SY_SS_N] & osc_running_o;

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [7:0] cfg_q;
   reg [7:0] rx_en_q;
   reg [7:0] rx_st_q;
   reg [7:0] tx_en_q;
   reg [7:0] tx_st_q;
   reg [7:0] wake_en_q;
   reg [7:0] wake_st_q;

   // Read decode, used for both first and burst reads
   function [7:0] read_reg;
      input [5:0] a;
      begin
         case (a)
            `ADDR_IRQ_CFG:   read_reg = cfg_q;
            `ADDR_RX_IRQ_EN: read_reg = rx_en_q;
            `ADDR_RX_IRQ_ST: read_reg = rx_st_q;
            `ADDR_TX_IRQ_EN: read_reg = tx_en_q;
            `ADDR_TX_IRQ_ST: read_reg = tx_st_q;
            `ADDR_WAKE_EN:   read_reg = wake_en_q;
            `ADDR_WAKE_ST:   read_reg = wake_st_q;
            default:         read_reg = `RST_ZERO8;
         endcase
      end
   endfunction

   // ****************************************************************
   // Serial slave engine
   // ****************************************************************
   reg [2:0] bit_q;
   reg [7:0] in_sh_q;
   reg [7:0] out_sh_q;
   reg       in_data_q;
   reg       dir_wr_q;
   reg       inc_q;
   reg [5:0] addr_q;
   wire [7:0] byte_in;
   wire      byte_done;
   reg       wr_stb;
   reg [5:0] wr_addr;
   reg       rd_stb;
   reg [5:0] rd_addr;

   assign byte_in   = {in_sh_q[6:0], sy[`SY_MOSI]};
   assign byte_done = ss_act & sck_rise & (bit_q == `BIT_LAST);

   // Register access strobes from completed bytes
   always @* begin
      wr_stb  = 1'b0;
      wr_addr = addr_q;
      rd_stb  = 1'b0;
      rd_addr = addr_q;
      if (byte_done) begin
         if (!in_data_q) begin
            rd_stb  = ~byte_in[`CMD_DIR_BIT];
            rd_addr = byte_in[`CMD_ADDR_MSB:0];
         end else if (dir_wr_q) begin
            wr_stb  = 1'b1;
         end else begin
            rd_stb  = 1'b1;
            rd_addr = inc_q ? addr_q + 6'h01 : addr_q;
         end
      end
   end

   // Shift, byte framing and address tracking
   always @(posedge clk_i) begin
      if (srst_i) begin
         bit_q     <= `BIT_FIRST;
         in_sh_q   <= `RST_ZERO8;
         out_sh_q  <= `RST_ZERO8;
         in_data_q <= 1'b0;
         dir_wr_q  <= 1'b0;
         inc_q     <= 1'b0;
         addr_q    <= 6'h00;
         miso_o    <= 1'b0;
         miso_oe_o <= 1'b0;
      end else if (!ss_act) begin
         bit_q     <= `BIT_FIRST;
         in_data_q <= 1'b0;
         miso_oe_o <= 1'b0;
      end else begin
         miso_oe_o <= 1'b1;
         if (sck_rise) begin
            in_sh_q <= byte_in;
            bit_q   <= bit_q + 3'h1;
            if (byte_done) begin
               in_data_q <= 1'b1;
               if (!in_data_q) begin
                  dir_wr_q <= byte_in[`CMD_DIR_BIT];
                  inc_q    <= byte_in[`CMD_INC_BIT];
                  addr_q   <= byte_in[`CMD_ADDR_MSB:0];
               end else if (inc_q) begin
                  addr_q   <= addr_q + 6'h01;
               end
               if (rd_stb) begin
                  out_sh_q <= read_reg(rd_addr);
               end
            end
         end
         if (sck_fall) begin
            miso_o   <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b0};
         end
      end
   end

   // ****************************************************************
   // Oscillator start and wake
   // ****************************************************************
   reg [15:0] osc_cnt_q;

   // Count start-up time after the power-down pin rises
   always @(posedge clk_i) begin
      if (srst_i) begin
         osc_cnt_q     <= 16'h0000;
         osc_running_o <= 1'b0;
      end else if (!sy[`SY_PD_N]) begin
         osc_cnt_q     <= 16'h0000;
         osc_running_o <= 1'b0;
      end else if (osc_cnt_q != OSC_CYC) begin
         osc_cnt_q     <= osc_cnt_q + 16'h0001;
      end else begin
         osc_running_o <= 1'b1;
      end
   end

   wire wake_evt;
   assign wake_evt = sy[`SY_PD_N] & ~osc_running_o & (osc_cnt_q == OSC_CYC);

   // ****************************************************************
   // Register writes and status capture
   // ****************************************************************
   wire [7:0] rx_evt_gated;
   wire       chan_b_off;
   wire       rd_clr;

   assign chan_b_off = (baseband_mode_i == `MODE_64_SINGLE) |
                       (baseband_mode_i == `MODE_32_DDR);
   assign rx_evt_gated = chan_b_off ? (rx_event_i & `RX_CHAN_A_MASK)
                                    : rx_event_i;
   assign rd_clr = rd_stb & ss_act;

   always @(posedge clk_i) begin
      if (srst_i) begin
         cfg_q     <= `RST_IRQ_CFG;
         rx_en_q   <= `RST_ZERO8;
         rx_st_q   <= `RST_ZERO8;
         tx_en_q   <= `RST_ZERO8;
         tx_st_q   <= `RST_ZERO8;
         wake_en_q <= `RST_ZERO8;
         wake_st_q <= `RST_WAKE_ST;
      end else begin
         if (wr_stb) begin
            case (wr_addr)
               `ADDR_IRQ_CFG:   cfg_q     <= byte_in;
               `ADDR_RX_IRQ_EN: rx_en_q   <= byte_in;
               `ADDR_TX_IRQ_EN: tx_en_q   <= byte_in;
               `ADDR_WAKE_EN:   wake_en_q <= byte_in;
               default:         cfg_q     <= cfg_q;
            endcase
         end
         // Status clears on read; a same-cycle event still lands
         rx_st_q <= ((rd_clr && rd_addr == `ADDR_RX_IRQ_ST) ?
                     `RST_ZERO8 : rx_st_q) | rx_evt_gated;
         tx_st_q <= ((rd_clr && rd_addr == `ADDR_TX_IRQ_ST) ?
                     `RST_ZERO8 : tx_st_q) |
                    ({4'h0, tx_event_i} & `TX_EVT_MASK);
         wake_st_q[`WAKE_BIT] <=
            ((rd_clr && rd_addr == `ADDR_WAKE_ST) ?
             1'b0 : wake_st_q[`WAKE_BIT]) | wake_evt;
      end
   end

   // ****************************************************************
   // Bypass bit path
   // ****************************************************************
   wire       byp_en;
   reg [7:0]  div_q;
   reg        bclk_q;
   wire       half_tick;
   wire       fall_tick;
   wire       f_in_valid;
   wire [1:0] f_in_data;
   wire       f_in_ready;
   wire       f_out_valid;
   wire [1:0] f_out_data;
   wire       f_out_ready;

   assign byp_en    = cfg_q[`CFG_BYPASS_BIT];
   assign half_tick = byp_en & (div_q == HALF_CYC - 8'h01) &
                      ~(tx_mode_i & ~f_in_ready);
   assign fall_tick = half_tick & bclk_q;

   // Bit clock divider; stalls while transmit bits have no room
   always @(posedge clk_i) begin
      if (srst_i || !byp_en) begin
         div_q  <= 8'h00;
         bclk_q <= 1'b0;
      end else if (half_tick) begin
         div_q  <= 8'h00;
         bclk_q <= ~bclk_q;
      end else if (div_q != HALF_CYC - 8'h01) begin
         div_q  <= div_q + 8'h01;
      end
   end

   // One FIFO, filled by the core or by the pins depending on mode
   assign f_in_valid  = tx_mode_i ? (fall_tick & sy[`SY_BYPASS_BIT_VALID])
                                  : core_rx_valid_i;
   assign f_in_data   = tx_mode_i ? {1'b1, sy[`SY_DIO]}
                                  : {1'b1, core_rx_bit_i};
   assign f_out_ready = tx_mode_i ? core_tx_ready_i : fall_tick;
   assign core_rx_ready_o = ~tx_mode_i & f_in_ready;
   assign core_tx_valid_o = tx_mode_i & f_out_valid;
   assign core_tx_bit_o   = f_out_data[0];

   bypass_fifo #(
      .WIDTH (2),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (f_in_valid),
      .in_data_i   (f_in_data),
      .in_ready_o  (f_in_ready),
      .out_valid_o (f_out_valid),
      .out_data_o  (f_out_data),
      .out_ready_i (f_out_ready)
   );

   // Receive bits change right after each falling bit clock edge
   always @(posedge clk_i) begin
      if (srst_i) begin
         bypass_serial_bit_o    <= 1'b0;
         bypass_bit_valid_o     <= 1'b0;
         bypass_serial_bit_oe_o <= 1'b0;
         bypass_bit_valid_oe_o  <= 1'b0;
      end else begin
         bypass_serial_bit_oe_o <= byp_en & ~tx_mode_i;
         bypass_bit_valid_oe_o  <= byp_en & ~tx_mode_i;
         if (fall_tick && !tx_mode_i) begin
            bypass_serial_bit_o <= f_out_valid & f_out_data[0];
            bypass_bit_valid_o  <= f_out_valid;
         end
      end
   end

   // ****************************************************************
   // Interrupt pin
   // ****************************************************************
   wire [7:0] rx_en_eff;
   wire       irq_act;
   wire       pol_high;

   assign rx_en_eff = tx_mode_i ? `RST_ZERO8 : rx_en_q;
   assign irq_act   = (|(rx_st_q & rx_en_eff)) |
                      (|(tx_st_q & tx_en_q)) |
                      (wake_st_q[`WAKE_BIT] & wake_en_q[`WAKE_BIT]);
   assign pol_high  = cfg_q[`CFG_POL_BIT];

   // Bypass drives the bit clock; otherwise open drain or open source
   always @(posedge clk_i) begin
      if (srst_i) begin
         irq_o    <= 1'b0;
         irq_oe_o <= 1'b0;
      end else if (byp_en) begin
         irq_o    <= half_tick ? ~bclk_q : bclk_q;
         irq_oe_o <= 1'b1;
      end else begin
         irq_o    <= pol_high;
         irq_oe_o <= irq_act;
      end
   end

endmodule // radio_host_spi_irq_interface

// file: verilog/radio_spi_defines.vh
// Constants shared by the radio host serial port and interrupt logic
`ifndef RADIO_SPI_DEFINES_VH
`define RADIO_SPI_DEFINES_VH

// ****************************************************************
// Register map (6-bit register addresses)
// ****************************************************************
`define ADDR_IRQ_CFG      6'h05
`define ADDR_RX_IRQ_EN    6'h07
`define ADDR_RX_IRQ_ST    6'h08
`define ADDR_TX_IRQ_EN    6'h0d
`define ADDR_TX_IRQ_ST    6'h0e
`define ADDR_WAKE_EN      6'h1c
`define ADDR_WAKE_ST      6'h1d

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_IRQ_CFG       8'h01
`define RST_WAKE_ST       8'h01
`define RST_ZERO8         8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CMD_DIR_BIT       7
`define CMD_INC_BIT       6
`define CMD_ADDR_MSB      5
`define CFG_POL_BIT       0
`define CFG_BYPASS_BIT    2
`define WAKE_BIT          0
`define RX_CHAN_A_MASK    8'h0f
`define TX_EVT_MASK       8'h0f

// ****************************************************************
// Baseband modes
// ****************************************************************
`define MODE_64_SINGLE    2'h0
`define MODE_32_DUAL      2'h1
`define MODE_32_OVERSAMP  2'h2
`define MODE_32_DDR       2'h3

// ****************************************************************
// Bit counting and timing
// ****************************************************************
`define BIT_LAST          3'h7
`define BIT_FIRST         3'h0
`define CLK_MHZ           250
`define NS_PER_US         1000

// ****************************************************************
// Synchronised pin bus positions
// ****************************************************************
`define SY_SCK            0
`define SY_SS_N           1
`define SY_MOSI           2
`define SY_PD_N           3
`define SY_DIO            4
`define SY_BYPASS_BIT_VALID         5
`define SY_WIDTH          6

`endif

// file: verilog/pin_sync3.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
   parameter W = 1
) (
   input  wire         clk_i,
   input  wire         srst_i,
   input  wire [W-1:0] pin_i,
   output reg  [W-1:0] level_o
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   integer     k;

   // Three flops; a bit moves only once stages two and three agree
   always @(posedge clk_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (srst_i) begin
         level_o <= {W{1'b0}};
      end else begin
         for (k = 0; k < W; k = k + 1) begin
            if (s2_q[k] == s3_q[k]) begin
               level_o[k] <= s3_q[k];
            end
         end
      end
   end

endmodule // pin_sync3

// file: verilog/bypass_fifo.v
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bypass_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_i,
   input  wire             srst_i,
   input  wire             in_valid_i,
   input  wire [WIDTH-1:0] in_data_i,
   output wire             in_ready_o,
   output wire             out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input  wire             out_ready_i
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign out_data_o  = mem_q[rd_q];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Storage write
   always @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // Pointers and fill count
   always @(posedge clk_i) begin
      if (srst_i) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule // bypass_fifo

// file: test/radio_host_spi_irq_interface_assertions.sv
// Port relation checker for the radio host serial and interrupt block
`timescale 1ns/1ps
module radio_port_checker #(
   parameter OSC_START_NS = 2000
) (
   input wire clk_i,
   input wire srst_i,
   input wire ss_n_i,
   input wire miso_oe_o,
   input wire power_down_pin_n_i,
   input wire osc_running_o,
   input wire irq_oe_o,
   input wire tx_mode_i,
   input wire bypass_serial_bit_oe_o,
   input wire bypass_bit_valid_oe_o,
   input wire core_tx_valid_o,
   input wire core_tx_ready_i
);
   localparam int OSC_CYC = OSC_START_NS * 250 / 1000;
   localparam int OSC_MAX = OSC_CYC + 8;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // Start-up steps after the power pin is released
   sequence pd_rel_s;
      $rose(power_down_pin_n_i);
   endsequence
   sequence osc_up_s;
      ##[1:OSC_MAX] (osc_running_o || !power_down_pin_n_i);
   endsequence
   a_osc_start_bound: assert property (pd_rel_s |-> osc_up_s)
      else $error("oscillator did not start in time");
   a_osc_rise_pd: assert property ($rose(osc_running_o) |->
      $past(power_down_pin_n_i, 8))
      else $error("oscillator started too soon");
   a_pd_stops_osc: assert property ((!power_down_pin_n_i) [*8] |->
      !osc_running_o)
      else $error("oscillator runs in power down");
   a_miso_needs_osc: assert property (miso_oe_o |->
      (osc_running_o || $past(osc_running_o)))
      else $error("serial output driven while stopped");
   a_ss_idle_oe: assert property (ss_n_i [*8] |-> !miso_oe_o)
      else $error("serial output driven while deselected");
   a_byp_tx_float: assert property (tx_mode_i [*3] |->
      !(bypass_serial_bit_oe_o || bypass_bit_valid_oe_o))
      else $error("bypass pins driven in transmit");
   a_fifo_hold_valid: assert property (
      core_tx_valid_o && !core_tx_ready_i |=> core_tx_valid_o)
      else $error("transmit valid dropped while stalled");
   a_reset_quiet: assert property ($fell(srst_i) |->
      !(irq_oe_o || miso_oe_o || osc_running_o))
      else $error("outputs active after reset");
endmodule // radio_port_checker

bind radio_host_spi_irq_interface radio_port_checker #(
   .OSC_START_NS(OSC_START_NS)
) u_chk (
   .clk_i(clk_i), .srst_i(srst_i), .ss_n_i(ss_n_i),
   .miso_oe_o(miso_oe_o), .power_down_pin_n_i(power_down_pin_n_i),
   .osc_running_o(osc_running_o), .irq_oe_o(irq_oe_o),
   .tx_mode_i(tx_mode_i), .bypass_serial_bit_oe_o(bypass_serial_bit_oe_o),
   .bypass_bit_valid_oe_o(bypass_bit_valid_oe_o),
   .core_tx_valid_o(core_tx_valid_o), .core_tx_ready_i(core_tx_ready_i)
);

// file: test/spi_host_model.sv
// Serial bus master model standing for the host controller
`timescale 1ns/1ps
module spi_host_model (
   output reg  sck_o,
   output reg  ss_n_o,
   output reg  mosi_o,
   input  wire miso_i,
   input  wire miso_oe_i
);
   reg  last_q;
   wire seen = miso_oe_i ? miso_i : ~last_q;
   // Released line shows the inverse of its last driven level
   always @(miso_i or miso_oe_i) if (miso_oe_i) last_q = miso_i;
   initial begin
      sck_o = 1'b0;
      ss_n_o = 1'b1;
      mosi_o = 1'b0;
      last_q = 1'b0;
   end
   // Select low before any clock edge; clock idles low
   task start;
      ss_n_o = 1'b0;
      #40;
   endtask
   // Select held over all bytes, raised only at the end
   task stop;
      #40;
      ss_n_o = 1'b1;
      #100;
   endtask
   // One byte, MSB first; MISO read late in the high phase
   task xfer(input [7:0] tx, output [7:0] rx);
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         mosi_o = tx[i];
         #16 sck_o = 1'b1;
         #14 rx[i] = seen;
         #2 sck_o = 1'b0;
      end
   endtask
endmodule // spi_host_model

// file: test/testbench.sv
// Self-checking bench for the radio host serial and interrupt block
`timescale 1ns/1ps
`include "radio_spi_defines.vh"
module testbench;
   reg        clk_i = 0, srst_i = 1, power_down_pin_n_i = 1, tx_mode_i = 0;
   reg  [3:0] tx_event_i = 0;
   reg  [7:0] rx_event_i = 0;
   reg  [1:0] baseband_mode_i = 0;
   reg        core_rx_bit_i = 0, core_rx_valid_i = 0, core_tx_ready_i = 0;
   reg        byp_bit_host = 0, byp_val_host = 0;
   wire       sck_i, ss_n_i, mosi_i, miso_o, miso_oe_o, osc_running_o;
   wire       irq_o, irq_oe_o, core_rx_ready_o, core_tx_bit_o;
   wire       bypass_serial_bit_o, bypass_serial_bit_oe_o, core_tx_valid_o;
   wire       bypass_bit_valid_o, bypass_bit_valid_oe_o;
   wire       irq_i = irq_oe_o ? irq_o : ~irq_o;
   wire       bypass_serial_bit_i = bypass_serial_bit_oe_o ?
                 bypass_serial_bit_o : byp_bit_host;
   wire       bypass_bit_valid_i = bypass_bit_valid_oe_o ?
                 bypass_bit_valid_o : byp_val_host;
   integer    n_mismatch = 0, checked = 0, k, m;
   reg [31:0] rd_q;
   reg        byp_bit_seen = 0, byp_val_seen = 0;
   // Host side of the bypass path takes bits on the rising bit clock
   always @(posedge irq_i) begin
      byp_bit_seen <= bypass_serial_bit_i;
      byp_val_seen <= bypass_bit_valid_i;
   end
   radio_host_spi_irq_interface #(.OSC_START_NS(40), .BYP_HALF_CYC(4)) dut (
      .clk_i, .srst_i, .sck_i, .ss_n_i, .mosi_i, .miso_o, .miso_oe_o,
      .power_down_pin_n_i, .osc_running_o, .irq_i, .irq_o, .irq_oe_o,
      .bypass_serial_bit_i, .bypass_serial_bit_o, .bypass_serial_bit_oe_o,
      .bypass_bit_valid_i, .bypass_bit_valid_o, .bypass_bit_valid_oe_o,
      .tx_mode_i, .baseband_mode_i, .tx_event_i, .rx_event_i,
      .core_rx_bit_i, .core_rx_valid_i, .core_rx_ready_o, .core_tx_bit_o,
      .core_tx_valid_o, .core_tx_ready_i);
   spi_host_model host (.sck_o(sck_i), .ss_n_o(ss_n_i), .mosi_o(mosi_i),
      .miso_i(miso_o), .miso_oe_i(miso_oe_o));
   // Clock of 4 ns period
   always #2 clk_i = ~clk_i;
   task check(input [31:0] seen, input [31:0] exp, input string what);
      checked = checked + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Command byte then n data bytes; read bytes gather in rd_q
   task access(input [7:0] cmd, input [31:0] wd, input integer n);
      reg [7:0] rx;
      integer j;
      rd_q = 0;
      host.start;
      host.xfer(cmd, rx);
      for (j = 0; j < n; j = j + 1) begin
         host.xfer(wd[31:24], rx);
         rd_q = {rd_q[23:0], rx};
         wd = wd << 8;
      end
      host.stop;
   endtask
   task wr(input [5:0] a, input [7:0] d);
      access({2'b10, a}, {d, 24'h0}, 1);
   endtask
   task rdc(input [5:0] a, input [7:0] e, input string w);
      access({2'b00, a}, 0, 1);
      check(rd_q[7:0], e, w);
   endtask
   task pulse(input [3:0] t, input [7:0] r);
      tx_event_i = t;
      rx_event_i = r;
      tick(1);
      tx_event_i = 0;
      rx_event_i = 0;
      tick(3);
   endtask
   task wait_osc;
      k = 0;
      while (osc_running_o !== 1'b1 && k < 100) begin
         tick(1);
         k = k + 1;
      end
      check(osc_running_o, 1, "osc_running");
   endtask
   task stop_test;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      stop_test;
   end
   // Main sequence
   initial begin
      tick(8);
      srst_i = 0;
      wait_osc;
      access(8'h45, 0, 3);
      check(rd_q[23:0], 24'h010000, "burst_inc");
      check(irq_oe_o, 0, "irq_wake_off");
      rdc(`ADDR_WAKE_ST, 8'h01, "wake_set");
      rdc(`ADDR_WAKE_ST, 8'h00, "wake_clr");
      $display("test reset and map done");
      wr(`ADDR_TX_IRQ_ST, 8'hff);
      wr(6'h3f, 8'haa);
      rdc(6'h3f, 8'h00, "unmapped");
      access({2'b11, `ADDR_TX_IRQ_EN}, 32'h01550000, 2);
      access({2'b00, `ADDR_TX_IRQ_EN}, 0, 2);
      check(rd_q[15:0], 16'h0101, "same_addr");
      rdc(`ADDR_TX_IRQ_ST, 8'h00, "status_ro");
      $display("test access kinds done");
      wr(`ADDR_WAKE_EN, 8'h01);
      rdc(`ADDR_WAKE_EN, 8'h01, "wake_en");
      power_down_pin_n_i = 0;
      tick(20);
      check(osc_running_o, 0, "osc_stop");
      power_down_pin_n_i = 1;
      wait_osc;
      tick(3);
      check({irq_oe_o, irq_o}, 2'b11, "wake_irq");
      rdc(`ADDR_WAKE_ST, 8'h01, "wake_read");
      tick(2);
      check(irq_oe_o, 0, "wake_cleared");
      $display("test wake done");
      pulse(4'h2, 0);
      check(irq_oe_o, 0, "tx_masked");
      pulse(4'h1, 0);
      check(irq_oe_o, 1, "tx_irq");
      wr(`ADDR_IRQ_CFG, 8'h00);
      tick(2);
      check({irq_oe_o, irq_o}, 2'b10, "open_drain");
      access({2'b01, `ADDR_TX_IRQ_EN}, 0, 2);
      check(rd_q[15:0], 16'h0103, "tx_status");
      tick(2);
      check(irq_oe_o, 0, "tx_cleared");
      wr(`ADDR_IRQ_CFG, 8'h01);
      $display("test transmit interrupts done");
      wr(`ADDR_RX_IRQ_EN, 8'hff);
      for (m = 0; m < 4; m = m + 1) begin
         baseband_mode_i = m[1:0];
         pulse(0, 8'h80);
         check(irq_oe_o, (m == 1 || m == 2), "chan_b_irq");
         pulse(0, 8'h01);
         check(irq_oe_o, 1, "chan_a_irq");
         access({2'b00, `ADDR_RX_IRQ_ST}, 0, 2);
         check(rd_q[15:8], (m == 1 || m == 2) ? 8'h81 : 8'h01, "rx_st");
         check(rd_q[7:0], 8'h00, "rx_clr");
      end
      tx_mode_i = 1;
      pulse(0, 8'h01);
      check(irq_oe_o, 0, "rx_in_tx");
      rdc(`ADDR_RX_IRQ_ST, 8'h01, "rx_polled");
      rdc(`ADDR_RX_IRQ_EN, 8'hff, "rx_en_kept");
      tx_mode_i = 0;
      $display("test receive interrupts done");
      wr(`ADDR_IRQ_CFG, 8'h05);
      core_rx_bit_i = 1;
      core_rx_valid_i = 1;
      k = 0;
      while (core_rx_ready_o === 1'b1 && k < 40) begin
         tick(1);
         k = k + 1;
      end
      check(core_rx_ready_o, 0, "rx_full");
      core_rx_valid_i = 0;
      tick(12);
      check({bypass_bit_valid_oe_o, bypass_bit_valid_o}, 2'b11, "byp_v");
      check(bypass_serial_bit_o, 1, "byp_bit");
      check(irq_oe_o, 1, "bit_clock");
      check({byp_val_seen, byp_bit_seen}, 2'b11, "host_byp");
      tick(200);
      check(bypass_bit_valid_o, 0, "byp_empty");
      check(byp_val_seen, 0, "host_byp_empty");
      byp_val_host = 1;
      core_tx_ready_i = 0;
      tx_mode_i = 1;
      tick(300);
      check({core_tx_valid_o, core_tx_bit_o}, 2'b10, "byp_tx");
      byp_val_host = 0;
      tick(20);
      core_tx_ready_i = 1;
      k = 0;
      while (core_tx_valid_o === 1'b1 && k < 40) begin
         tick(1);
         k = k + 1;
      end
      check(k, 16, "tx_drain");
      tx_mode_i = 0;
      wr(`ADDR_IRQ_CFG, 8'h01);
      $display("test bypass done");
      stop_test;
   end
endmodule // testbench
